/* design/smf_pkg.sv */
// constants, register map and types of the sensor mirror and frame event stage
package smf_pkg;
	// ******************************
	// register map (byte addresses)
	// ******************************
	localparam int unsigned SMF_AW = 8;
	localparam logic [7:0] SMF_OFF_CTRL      = 8'h00;
	localparam logic [7:0] SMF_OFF_CORNER    = 8'h04;
	localparam logic [7:0] SMF_OFF_LINE_W    = 8'h08;
	localparam logic [7:0] SMF_OFF_FRAME_H   = 8'h0c;
	localparam logic [7:0] SMF_OFF_COL_START = 8'h10;
	localparam logic [7:0] SMF_OFF_ROI_W     = 8'h14;
	localparam logic [7:0] SMF_OFF_ROW_START = 8'h18;
	localparam logic [7:0] SMF_OFF_ROI_H     = 8'h1c;
	localparam logic [7:0] SMF_OFF_IDS       = 8'h20;
	localparam logic [7:0] SMF_OFF_STATUS    = 8'h24;
	// ******************************
	// field positions
	// ******************************
	localparam int unsigned SMF_CTRL_RUN    = 0;
	localparam int unsigned SMF_CTRL_LAYOUT = 1;
	localparam int unsigned SMF_CTRL_LSCAN  = 2;
	localparam int unsigned SMF_ST_HLIM     = 0;
	localparam int unsigned SMF_ST_VLIM     = 1;
	localparam int unsigned SMF_ST_ODD      = 2;
	localparam int unsigned SMF_ST_BUSY     = 3;
	localparam int unsigned SMF_ST_WRANGE   = 4;
	// ******************************
	// widths and reset values
	// ******************************
	localparam int unsigned SMF_WW = 16;
	localparam int unsigned SMF_HW = 17;
	localparam logic [15:0] SMF_RST_LINE_W  = 16'h0400;
	localparam logic [16:0] SMF_RST_FRAME_H = 17'h0_0400;
	localparam logic [15:0] SMF_RST_ROI_W   = 16'h0400;
	localparam logic [16:0] SMF_RST_ROI_H   = 17'h0_0400;
	localparam logic [7:0]  SMF_RST_ID0     = 8'h00;
	localparam logic [7:0]  SMF_RST_ID1     = 8'h01;
	localparam logic [7:0]  SMF_ID_TOP      = 8'hff;
	localparam logic [15:0] SMF_MIN_LINE_W  = 16'h0030;
	localparam logic [15:0] SMF_MAX_LINE_W  = 16'h8000;
	localparam logic [15:0] SMF_STEP_MASK   = 16'h000f;
	localparam logic SMF_SINGLE_ZONE = 1'b0;
	localparam logic SMF_TWO_ZONE    = 1'b1;
	// ******************************
	// types
	// ******************************
	typedef enum logic [1:0] {
		CORNER_UPPER_LEFT  = 2'b00,
		CORNER_UPPER_RIGHT = 2'b01,
		CORNER_LOWER_LEFT  = 2'b10,
		CORNER_LOWER_RIGHT = 2'b11
	} smf_corner_t;
	typedef enum logic [1:0] {
		ST_PASS  = 2'b00,
		ST_FILL  = 2'b01,
		ST_DRAIN = 2'b10
	} smf_state_t;
endpackage

/* design/smf_top.sv */
// pixel fifo and the sensor mirror / frame event stage
// What this block does
// - one shared error event path for both taps
// - error event carries the tap stream identifier
// - tap 1 identifier always above tap 0
// - frame begin on first pixel arrival
// - frame events only while acquisition runs
// - assembled frame begins with first camera line
// - area scan frame finish right after last pixel arrives
// - line scan finish when last pixel leaves
// - four viewing corners, mirror the full image
// - mirrored column start plus width within line
// - row start plus height within frame height when vertically mirrored or two zone
// - full width mirrors lines, ignored when left
// - unmirrored line width is start plus width
// - vertical mirror double buffers in dram
// - two zone subframes merge into one frame
`timescale 1ns/1ps
module smf_fifo #(
	parameter int W     = 18,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	// fill side
	input  wire logic                   in_valid_i,
	output logic                        in_ready_o,
	input  wire logic [W-1:0]           in_data_i,
	// drain side
	output logic                        out_valid_o,
	input  wire logic                   out_ready_i,
	output logic [W-1:0]                out_data_o,
	output logic [$clog2(DEPTH):0]      level_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	assign level_o     = wr_ptr - rd_ptr;
	assign in_ready_o  = level_o != (AW+1)'(DEPTH);
	assign out_valid_o = level_o != '0;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge clk_i) begin
		if (in_valid_i && in_ready_o) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid_i && in_ready_o) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid_o && out_ready_i) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

module smf_top import smf_pkg::*; #(
	parameter int PIX_W    = 16,
	parameter int MAX_LINE = 32768,
	parameter int DEPTH    = 32
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	// apb slave
	input  wire logic [SMF_AW-1:0] paddr_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [31:0]       pwdata_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// tap streams
	input  wire logic              tap0_valid_i,
	input  wire logic [PIX_W-1:0]  tap0_data_i,
	output logic                   tap0_ready_o,
	input  wire logic              tap1_valid_i,
	input  wire logic [PIX_W-1:0]  tap1_data_i,
	output logic                   tap1_ready_o,
	// per tap stream errors
	input  wire logic              err0_valid_i,
	input  wire logic [3:0]        err0_flags_i,
	input  wire logic              err1_valid_i,
	input  wire logic [3:0]        err1_flags_i,
	// pixel output
	output logic                   out_valid_o,
	input  wire logic              out_ready_i,
	output logic [PIX_W-1:0]       out_data_o,
	output logic                   out_eol_o,
	output logic                   out_eof_o,
	output logic                   vflip_o,
	output logic                   bank_o,
	// events
	output logic                   frame_begin_event_o,
	output logic                   frame_finish_event_o,
	output logic                   stream_error_event_o,
	output logic [7:0]             stream_error_id_o,
	output logic [3:0]             stream_error_flags_o
);
	localparam int LB_AW = $clog2(MAX_LINE);
	localparam int FW    = PIX_W + 2;
	localparam int LVW   = $clog2(DEPTH) + 1;
	localparam logic [LVW-1:0] LV_SAFE = LVW'(DEPTH - 2);

	// ******************************
	// registers
	// ******************************
	logic              run;
	logic              tap_layout;
	logic              lscan;
	smf_corner_t       viewing_corner;
	logic [SMF_WW-1:0] full_line_width;
	logic [SMF_HW-1:0] full_frame_height;
	logic [SMF_WW-1:0] region_column_start;
	logic [SMF_WW-1:0] roi_w;
	logic [SMF_HW-1:0] region_row_start;
	logic [SMF_HW-1:0] roi_h;
	logic [7:0]        id0;
	logic [7:0]        id1;
	logic              acc_phase;
	logic              wr_en;
	logic              hmirror;
	logic              vmirror;
	logic              two_zone;
	logic [31:0]       rd_mux;
	logic              addr_ok;
	logic [4:0]        status;
	smf_state_t        state;

	assign acc_phase = psel_i && penable_i;
	assign wr_en     = acc_phase && pready_o && pwrite_i && addr_ok;
	assign hmirror   = viewing_corner[0];
	assign vmirror   = viewing_corner[1];
	assign two_zone  = tap_layout == SMF_TWO_ZONE;

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else begin
			pready_o  <= acc_phase && !pready_o;
			pslverr_o <= acc_phase && !pready_o && !addr_ok;
			prdata_o  <= (acc_phase && !pready_o && !pwrite_i) ? rd_mux : '0;
		end
	end

	// geometry is locked while running so a line never changes shape
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			run                 <= 1'b0;
			tap_layout          <= SMF_SINGLE_ZONE;
			lscan               <= 1'b0;
			viewing_corner      <= CORNER_UPPER_LEFT;
			full_line_width     <= SMF_RST_LINE_W;
			full_frame_height   <= SMF_RST_FRAME_H;
			region_column_start <= '0;
			roi_w               <= SMF_RST_ROI_W;
			region_row_start    <= '0;
			roi_h               <= SMF_RST_ROI_H;
			id0                 <= SMF_RST_ID0;
			id1                 <= SMF_RST_ID1;
		end else if (wr_en) begin
			if (paddr_i == SMF_OFF_CTRL) begin
				run   <= pwdata_i[SMF_CTRL_RUN];
				lscan <= pwdata_i[SMF_CTRL_LSCAN];
				if (!run) begin
					tap_layout <= pwdata_i[SMF_CTRL_LAYOUT];
				end
			end else if (paddr_i == SMF_OFF_IDS) begin
				id0 <= pwdata_i[7:0];
				id1 <= pwdata_i[15:8];
			end else if (!run) begin
				if (paddr_i == SMF_OFF_CORNER) begin
					viewing_corner <= smf_corner_t'(pwdata_i[1:0]);
				end else if (paddr_i == SMF_OFF_LINE_W) begin
					full_line_width <= pwdata_i[SMF_WW-1:0];
				end else if (paddr_i == SMF_OFF_FRAME_H) begin
					full_frame_height <= pwdata_i[SMF_HW-1:0];
				end else if (paddr_i == SMF_OFF_COL_START) begin
					region_column_start <= pwdata_i[SMF_WW-1:0];
				end else if (paddr_i == SMF_OFF_ROI_W) begin
					roi_w <= pwdata_i[SMF_WW-1:0];
				end else if (paddr_i == SMF_OFF_ROW_START) begin
					region_row_start <= pwdata_i[SMF_HW-1:0];
				end else if (paddr_i == SMF_OFF_ROI_H) begin
					roi_h <= pwdata_i[SMF_HW-1:0];
				end
			end
		end
	end

	// ******************************
	// geometry
	// ******************************
	logic [SMF_WW:0]   col_end;
	logic [SMF_HW:0]   row_end;
	logic [SMF_WW:0]   eff_w;
	logic [SMF_HW:0]   eff_h;
	logic [SMF_HW:0]   half_h;
	assign col_end = {1'b0, region_column_start} + {1'b0, roi_w};
	assign row_end = {1'b0, region_row_start} + {1'b0, roi_h};
	assign eff_w   = hmirror ? {1'b0, full_line_width} : col_end;
	assign eff_h   = (vmirror || two_zone) ? {1'b0, full_frame_height}
		: row_end;
	assign half_h  = {2'b00, full_frame_height[SMF_HW-1:1]};

	always_comb begin
		status                = '0;
		status[SMF_ST_HLIM]   = hmirror
			&& (col_end > {1'b0, full_line_width});
		status[SMF_ST_VLIM]   = (vmirror || two_zone)
			&& (row_end > {1'b0, full_frame_height});
		status[SMF_ST_ODD]    = two_zone && full_frame_height[0];
		status[SMF_ST_BUSY]   = state != ST_PASS;
		status[SMF_ST_WRANGE] = (full_line_width < SMF_MIN_LINE_W)
			|| (full_line_width > SMF_MAX_LINE_W)
			|| ((full_line_width & SMF_STEP_MASK) != '0);
	end

	always_comb begin
		addr_ok = 1'b1;
		rd_mux  = '0;
		if (paddr_i == SMF_OFF_CTRL) begin
			rd_mux[SMF_CTRL_RUN]    = run;
			rd_mux[SMF_CTRL_LAYOUT] = tap_layout;
			rd_mux[SMF_CTRL_LSCAN]  = lscan;
		end else if (paddr_i == SMF_OFF_CORNER) begin
			rd_mux[1:0] = viewing_corner;
		end else if (paddr_i == SMF_OFF_LINE_W) begin
			rd_mux[SMF_WW-1:0] = full_line_width;
		end else if (paddr_i == SMF_OFF_FRAME_H) begin
			rd_mux[SMF_HW-1:0] = full_frame_height;
		end else if (paddr_i == SMF_OFF_COL_START) begin
			rd_mux[SMF_WW-1:0] = region_column_start;
		end else if (paddr_i == SMF_OFF_ROI_W) begin
			rd_mux[SMF_WW-1:0] = roi_w;
		end else if (paddr_i == SMF_OFF_ROW_START) begin
			rd_mux[SMF_HW-1:0] = region_row_start;
		end else if (paddr_i == SMF_OFF_ROI_H) begin
			rd_mux[SMF_HW-1:0] = roi_h;
		end else if (paddr_i == SMF_OFF_IDS) begin
			rd_mux[15:0] = {id1, id0};
		end else if (paddr_i == SMF_OFF_STATUS) begin
			rd_mux[4:0] = status;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// ******************************
	// pixel path
	// ******************************
	logic [PIX_W-1:0]  lbuf [MAX_LINE];
	logic [SMF_WW:0]   col;
	logic [SMF_HW:0]   row;
	logic [SMF_WW:0]   rd;
	logic              drain_last;
	logic              sel1;
	logic              acc;
	logic [PIX_W-1:0]  pix;
	logic              last_col;
	logic              last_row;
	smf_state_t        next_state;
	logic [SMF_WW:0]   next_col;
	logic [SMF_HW:0]   next_row;
	logic              next_rdy;
	logic              f_in_valid;
	logic              f_in_ready;
	logic [FW-1:0]     f_in_data;
	logic              f_out_valid;
	logic              f_out_ready;
	logic [FW-1:0]     f_out_data;
	logic [LVW-1:0]    f_level;
	logic              ld;
	logic              drain_push;

	// lower zone rides tap 1, stalled until the upper zone is done
	assign sel1     = two_zone && (row >= half_h);
	assign acc      = sel1 ? (tap1_valid_i && tap1_ready_o)
		: (tap0_valid_i && tap0_ready_o);
	assign pix      = sel1 ? tap1_data_i : tap0_data_i;
	assign last_col = col == (eff_w - 1'b1);
	assign last_row = row == (eff_h - 1'b1);
	assign drain_push = (state == ST_DRAIN) && f_in_ready;

	always_comb begin
		next_col   = col;
		next_row   = row;
		next_state = state;
		if (acc) begin
			next_col = last_col ? '0 : col + 1'b1;
			if (last_col) begin
				next_row = last_row ? '0 : row + 1'b1;
			end
		end
		case (state)
			ST_PASS: begin
				if (hmirror && col == '0 && !acc) begin
					next_state = ST_FILL;
				end
			end
			ST_FILL: begin
				if (acc && last_col) begin
					next_state = ST_DRAIN;
				end else if (!hmirror && col == '0) begin
					next_state = ST_PASS;
				end
			end
			ST_DRAIN: begin
				if (drain_push && rd == '0) begin
					next_state = hmirror ? ST_FILL : ST_PASS;
				end
			end
			default: next_state = ST_PASS;
		endcase
		next_rdy = (next_state == ST_FILL)
			|| (next_state == ST_PASS && f_level < LV_SAFE);
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state        <= ST_PASS;
			col          <= '0;
			row          <= '0;
			tap0_ready_o <= 1'b0;
			tap1_ready_o <= 1'b0;
		end else begin
			state        <= next_state;
			col          <= next_col;
			row          <= next_row;
			tap0_ready_o <= next_rdy && !(two_zone && next_row >= half_h);
			tap1_ready_o <= next_rdy && two_zone && (next_row >= half_h);
		end
	end

	// the whole sensor line is stored, so cropping sees mirrored pixels
	always_ff @(posedge clk_i) begin
		if (state == ST_FILL && acc) begin
			lbuf[col[LB_AW-1:0]] <= pix;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd         <= '0;
			drain_last <= 1'b0;
		end else if (state == ST_FILL && acc && last_col) begin
			rd         <= col;
			drain_last <= last_row;
		end else if (drain_push && rd != '0) begin
			rd <= rd - 1'b1;
		end
	end

	always_comb begin
		if (state == ST_DRAIN) begin
			f_in_valid = 1'b1;
			f_in_data  = {drain_last && rd == '0, rd == '0,
				lbuf[rd[LB_AW-1:0]]};
		end else begin
			f_in_valid = (state == ST_PASS) && acc;
			f_in_data  = {last_col && last_row, last_col, pix};
		end
	end

	smf_fifo #(
		.W     (FW),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (f_in_valid),
		.in_ready_o  (f_in_ready),
		.in_data_i   (f_in_data),
		.out_valid_o (f_out_valid),
		.out_ready_i (f_out_ready),
		.out_data_o  (f_out_data),
		.level_o     (f_level)
	);

	assign f_out_ready = !out_valid_o || out_ready_i;
	assign ld          = f_out_valid && f_out_ready;

	// vertical flip is done by the dram stage, two banks per frame pair
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
			out_eol_o   <= 1'b0;
			out_eof_o   <= 1'b0;
			vflip_o     <= 1'b0;
			bank_o      <= 1'b0;
		end else begin
			out_valid_o <= ld || (out_valid_o && !out_ready_i);
			vflip_o     <= vmirror;
			if (ld) begin
				{out_eof_o, out_eol_o, out_data_o} <= f_out_data;
				if (f_out_data[FW-1] && vmirror) begin
					bank_o <= !bank_o;
				end
			end
		end
	end

	// ******************************
	// events
	// ******************************
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_begin_event_o  <= 1'b0;
			frame_finish_event_o <= 1'b0;
		end else begin
			frame_begin_event_o  <= run && acc && col == '0
				&& row == '0;
			frame_finish_event_o <= run && (lscan
				? (ld && f_out_data[FW-1])
				: (acc && last_col && last_row));
		end
	end

	logic [7:0] eid0;
	logic [7:0] eid1;
	logic       pend1;
	logic [3:0] pend_flags;
	assign eid0 = (id0 == SMF_ID_TOP) ? id0 - 1'b1 : id0;
	assign eid1 = (id1 > eid0) ? id1 : eid0 + 1'b1;

	// tap 0 wins a tie; tap 1 waits and merges later errors into one
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stream_error_event_o <= 1'b0;
			stream_error_id_o    <= '0;
			stream_error_flags_o <= '0;
			pend1                <= 1'b0;
			pend_flags           <= '0;
		end else begin
			stream_error_event_o <= err0_valid_i || pend1 || err1_valid_i;
			if (err0_valid_i) begin
				stream_error_id_o    <= eid0;
				stream_error_flags_o <= err0_flags_i;
				if (err1_valid_i) begin
					pend1      <= 1'b1;
					pend_flags <= pend_flags | err1_flags_i;
				end
			end else if (pend1 || err1_valid_i) begin
				stream_error_id_o    <= eid1;
				stream_error_flags_o <= pend_flags
					| (err1_valid_i ? err1_flags_i : 4'h0);
				pend1      <= 1'b0;
				pend_flags <= '0;
			end
		end
	end

	// ******************************
	// assertions
	// ******************************
	property p_begin_run;
		@(posedge clk_i) disable iff (sys_rst_i)
		frame_begin_event_o |-> $past(run) && $past(acc);
	endproperty
	a_begin_run: assert property (p_begin_run)
		else $error("frame begin without running acquisition");
	property p_finish_run;
		@(posedge clk_i) disable iff (sys_rst_i)
		!run ##1 !$past(run) |-> !frame_finish_event_o;
	endproperty
	a_finish_run: assert property (p_finish_run)
		else $error("frame finish while stopped");
	property p_begin_first;
		@(posedge clk_i) disable iff (sys_rst_i)
		run && acc && col == '0 && row == '0 |=> frame_begin_event_o;
	endproperty
	a_begin_first: assert property (p_begin_first)
		else $error("first pixel gave no frame begin");
	property p_area_finish;
		@(posedge clk_i) disable iff (sys_rst_i)
		run && !lscan && acc && last_col && last_row
		|=> frame_finish_event_o;
	endproperty
	a_area_finish: assert property (p_area_finish)
		else $error("last pixel gave no frame finish");
	property p_ls_finish;
		@(posedge clk_i) disable iff (sys_rst_i)
		run && lscan && ld && f_out_data[FW-1]
		|=> frame_finish_event_o && out_eof_o && out_valid_o;
	endproperty
	a_ls_finish: assert property (p_ls_finish)
		else $error("line scan finish not on leaving pixel");
	property p_id_order;
		@(posedge clk_i) disable iff (sys_rst_i)
		eid1 > eid0;
	endproperty
	a_id_order: assert property (p_id_order)
		else $error("tap 1 identifier not above tap 0");
	property p_err_tap0;
		@(posedge clk_i) disable iff (sys_rst_i)
		err0_valid_i |=> stream_error_event_o
			&& stream_error_id_o == $past(eid0);
	endproperty
	a_err_tap0: assert property (p_err_tap0)
		else $error("tap 0 error not reported with its id");
	property p_err_tap1;
		@(posedge clk_i) disable iff (sys_rst_i)
		err1_valid_i && err0_valid_i ##1 !err0_valid_i
		|=> stream_error_event_o && stream_error_id_o == $past(eid1);
	endproperty
	a_err_tap1: assert property (p_err_tap1)
		else $error("held tap 1 error not reported next");
	property p_mirror_drain;
		@(posedge clk_i) disable iff (sys_rst_i)
		state == ST_FILL && acc && last_col
		|=> state == ST_DRAIN && rd == $past(col) && !tap0_ready_o;
	endproperty
	a_mirror_drain: assert property (p_mirror_drain)
		else $error("full line did not start reversed drain");
	property p_width_sel;
		@(posedge clk_i) disable iff (sys_rst_i)
		!hmirror |-> eff_w == col_end;
	endproperty
	a_width_sel: assert property (p_width_sel)
		else $error("unmirrored line width not start plus width");
	property p_zone_tap;
		@(posedge clk_i) disable iff (sys_rst_i)
		two_zone && row < half_h |-> !tap1_ready_o;
	endproperty
	a_zone_tap: assert property (p_zone_tap)
		else $error("tap 1 taken during upper zone");
endmodule

/* dv/smf_cam.sv */
// camera tap source model: one frame of numbered pixels per go pulse
`timescale 1ns/1ps
module smf_cam #(
	parameter int NPIX = 96
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// control and tap stream
	input  wire logic        go_i,
	input  wire logic        ready_i,
	output logic             valid_o,
	output logic [15:0]      data_o
);
	int sent;
	int nxt;
	// random gaps make the source both prompt and slow
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sent = NPIX;
			valid_o <= 1'b0;
			data_o <= 16'h0000;
		end else if (go_i) begin
			sent = 0;
		end else if (!valid_o || ready_i) begin
			nxt = sent + int'(valid_o);
			sent = nxt;
			// a frame is exactly the pixel count the stage expects
			if (nxt < NPIX && $urandom_range(3) != 0) begin
				valid_o <= 1'b1;
				data_o <= nxt[15:0];
			end else begin
				valid_o <= 1'b0;
				// idle data toggles so stale pixels never look valid
				data_o <= ~data_o;
			end
		end
	end
endmodule

/* dv/smf_top_bench.sv */
// self-checking bench of the mirror and frame event stage
`timescale 1ns/1ps
module smf_top_bench import smf_pkg::*;;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0;
	logic e0v = 0, e1v = 0, ord = 0;
	logic [3:0] e0f = 0, e1f = 0, f0, f1, sfl;
	logic [7:0] paddr = 0, sid;
	logic [31:0] pwdata = 0, prdata;
	logic [15:0] t0d, t1d, od;
	logic pready, pslverr, t0v, t0r, ov, eol, eof, vfl, fb, ff, sev;
	logic t1v, t1r, bnk, eofq;
	int err_count = 0, num_checks = 0, cyc = 0, ntake, nb, nf;
	int tf0, tl, tb, tfe, eofi, teo, eolm;
	logic [15:0] q[$];
	logic [11:0] eq[$];

	smf_top #(.MAX_LINE(64)) dut (
		.clk_i(clk), .sys_rst_i(rst), .paddr_i(paddr), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.tap0_valid_i(t0v), .tap0_data_i(t0d), .tap0_ready_o(t0r),
		.tap1_valid_i(t1v), .tap1_data_i(t1d), .tap1_ready_o(t1r),
		.err0_valid_i(e0v), .err0_flags_i(e0f), .err1_valid_i(e1v),
		.err1_flags_i(e1f), .out_valid_o(ov), .out_ready_i(ord),
		.out_data_o(od), .out_eol_o(eol), .out_eof_o(eof),
		.vflip_o(vfl), .bank_o(bnk), .frame_begin_event_o(fb),
		.frame_finish_event_o(ff), .stream_error_event_o(sev),
		.stream_error_id_o(sid), .stream_error_flags_o(sfl));
	smf_cam cam (.clk_i(clk), .sys_rst_i(rst), .go_i(go), .ready_i(t0r),
		.valid_o(t0v), .data_o(t0d));
	// lower zone source, only taken in the two zone layout
	smf_cam cam1 (.clk_i(clk), .sys_rst_i(rst), .go_i(go), .ready_i(t1r),
		.valid_o(t1v), .data_o(t1d));

	initial begin
		forever #12.5 clk = ~clk;
	end

	// ********************
	// monitors
	// ********************
	always @(posedge clk) begin
		cyc++;
		ord <= 1'($urandom_range(1));
		if ((t0v && t0r) || (t1v && t1r)) begin
			if (ntake == 0) tf0 = cyc;
			tl = cyc;
			ntake++;
		end
		if (fb) begin
			nb++;
			tb = cyc;
		end
		if (ff) begin
			nf++;
			tfe = cyc;
		end
		if (ov && ord) begin
			q.push_back(od);
			if (eof) eofi = q.size();
			if (eol !== (q.size() % 48 == 0)) eolm++;
		end
		if (eof && !eofq) teo = cyc;
		eofq = eof;
		if (sev) eq.push_back({sid, sfl});
	end

	// ********************
	// tasks
	// ********************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// holds the request until pready is sampled, then releases it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] x, input logic xe);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(pready, 1'b1);
		if (!w) chk(prdata, x);
		chk(pslverr, xe);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [15:0] exp_pix(input int i, input logic hm);
		return hm ? 16'((i / 48) * 48 + 47 - i % 48) : 16'(i % 96);
	endfunction

	task automatic frame(input logic hm, input logic run, input logic ls,
		input int np);
		int n;
		n = 0;
		eolm = 0;
		q.delete();
		ntake = 0;
		nb = 0;
		nf = 0;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (q.size() < np && n < 3000) begin
			@(posedge clk);
			n++;
		end
		repeat (4) @(posedge clk);
		chk(q.size(), np);
		foreach (q[i]) chk(q[i], exp_pix(i, hm));
		chk(eofi, np);
		chk(eolm, 0);
		chk(nb, run);
		chk(nf, run);
		if (run) chk(tb, tf0 + 1);
		if (run) chk(tfe, ls ? teo : tl + 1);
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ********************
	// tests
	// ********************
	initial begin
		void'($urandom(81));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(0, SMF_OFF_LINE_W, 0, 32'h0000_0400, 0);
		apb(0, SMF_OFF_IDS, 0, 32'h0000_0100, 0);
		apb(0, SMF_OFF_CORNER, 0, 32'h0000_0000, 0);
		apb(0, 8'h3c, 0, 32'h0000_0000, 1);
		apb(1, SMF_OFF_ROI_W, 32'h0000_0030, 0, 0);
		apb(1, SMF_OFF_ROI_H, 32'h0000_0002, 0, 0);
		apb(1, SMF_OFF_FRAME_H, 32'h0000_0002, 0, 0);
		frame(0, 0, 0, 96);
		// left corners get a wrong line width that must be ignored
		for (int c = 0; c < 4; c++) begin
			apb(1, SMF_OFF_CTRL, 0, 0, 0);
			apb(1, SMF_OFF_CORNER, c, 0, 0);
			apb(1, SMF_OFF_LINE_W, c[0] ? 48 : 64, 0, 0);
			apb(1, SMF_OFF_CTRL, 1, 0, 0);
			frame(c[0], 1, 0, 96);
			chk(vfl, c[1]);
			chk(bnk, c[1] && !c[0]);
		end
		apb(1, SMF_OFF_CTRL, 0, 0, 0);
		// line scan finish timing, then the two zone layout
		apb(1, SMF_OFF_CORNER, 0, 0, 0);
		apb(1, SMF_OFF_CTRL, 32'h0000_0005, 0, 0);
		frame(0, 1, 1, 96);
		apb(1, SMF_OFF_CTRL, 0, 0, 0);
		apb(1, SMF_OFF_FRAME_H, 32'h0000_0004, 0, 0);
		apb(1, SMF_OFF_CTRL, 32'h0000_0003, 0, 0);
		frame(0, 1, 0, 192);
		// the layout bit only clears once the stage is stopped
		apb(1, SMF_OFF_CTRL, 0, 0, 0);
		apb(1, SMF_OFF_CTRL, 0, 0, 0);
		f0 = 4'($urandom_range(15, 1));
		f1 = 4'($urandom_range(15, 1));
		eq.delete();
		e0v <= 1'b1;
		e1v <= 1'b1;
		e0f <= f0;
		e1f <= f1;
		@(posedge clk);
		e0v <= 1'b0;
		e1v <= 1'b0;
		repeat (4) @(posedge clk);
		chk(eq.size(), 2);
		chk(eq[0], {8'h00, f0});
		chk(eq[1], {8'h01, f1});
		apb(1, SMF_OFF_IDS, 32'h0000_0505, 0, 0);
		e1v <= 1'b1;
		@(posedge clk);
		e1v <= 1'b0;
		repeat (4) @(posedge clk);
		chk(eq[2], {8'h06, f1});
		apb(1, SMF_OFF_CORNER, 1, 0, 0);
		apb(1, SMF_OFF_COL_START, 32'h0000_0010, 0, 0);
		// a right corner parks the mirror in fill, so busy reads set
		apb(0, SMF_OFF_STATUS, 0, 32'h0000_0009, 0);
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end
endmodule
